// >>> bench/cfg_checker.sv
`timescale 1ns/1ns
module cfg_checker (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// config access
	input wire logic cfg_sel,
	input wire logic cfg_write,
	input wire logic cfg_read,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_rdata,
	// bus side
	input wire logic [1:0] mem_hit,
	input wire logic [1:0] io_hit,
	input wire logic [1:0] special_cycle,
	input wire logic [1:0] master_req,
	input wire logic [1:0] addr_parity_err,
	input wire logic [1:0] data_parity_err,
	input wire logic [1:0] mem_claim,
	input wire logic [1:0] io_claim,
	input wire logic [1:0] master_grant_ok,
	input wire logic master_use_write_invalidate,
	input wire logic [1:0] palette_snoop,
	input wire logic perr_assert,
	input wire logic serr_assert,
	input wire logic serr_driver_enable
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_rd;
		cfg_sel && cfg_read && cfg_addr[7:2] == 6'h01;
	endsequence
	sequence s_wr;
		$past(cfg_sel && cfg_write);
	endsequence
	AST_FIXED_BITS: assert property (s_rd |=> (cfg_rdata & 32'h06ff_fe98) == 32'h0210_0000)
		else $error("fixed bits wrong");
	AST_REFUSED: assert property (cfg_rdata != 32'h0 |-> $past(cfg_sel && cfg_read))
		else $error("read data without read");
	AST_NO_MWI: assert property (!master_use_write_invalidate)
		else $error("write invalidate used");
	AST_MEM: assert property ((mem_claim & ~mem_hit) == 2'h0)
		else $error("memory claim without hit");
	AST_IO: assert property ((io_claim & (~io_hit | special_cycle)) == 2'h0)
		else $error("bad io claim");
	AST_MASTER: assert property ((master_grant_ok & ~master_req) == 2'h0)
		else $error("grant without request");
	AST_SERR: assert property (serr_assert |-> $past(|addr_parity_err) && $past(serr_driver_enable))
		else $error("serr without cause");
	AST_PERR: assert property (perr_assert |-> $past(|data_parity_err))
		else $error("perr without cause");
	AST_ENABLES: assert property ($changed({palette_snoop, serr_driver_enable}) |-> s_wr)
		else $error("enable moved without write");
endmodule : cfg_checker

// >>> bench/pci_agent_model.sv
`timescale 1ns/1ns
// far-side agents: one kind of bus activity at a time (two for code a), on the chosen functions
module pci_agent_model (
	// command from bench
	input wire logic [3:0] op,
	input wire logic [1:0] fn_sel,
	// bus-side activity
	output logic [1:0] ev [10]
);
	always_comb begin
		for (int i = 0; i < 10; i++) begin
			// code a pairs an io hit with a special cycle, which is never claimed
			ev[i] = (op == i[3:0] || (op == 4'ha && (i == 1 || i == 2))) ? fn_sel : 2'h0;
		end
	end
endmodule : pci_agent_model

// >>> bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic clock, resetn, cfg_sel, cfg_func, cfg_write, cfg_read, mwi, perr_a, serr_a, system_error_enable;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_byte_en, op;
	logic [31:0] cfg_wdata, rdata, q;
	logic [1:0] fs, mem_c, io_c, mgo, snoop, ep;
	logic [1:0] ev [10];
	logic [5:0] gexp [4] = '{6'h10, 6'h04, 6'h00, 6'h01};
	int n_fail = 0;
	int n_tests = 0;
	localparam logic [31:0] MSK = 32'hbfff_ffff;
	pci_config_command_status dut (.clock(clock), .resetn(resetn), .cfg_sel(cfg_sel),
		.cfg_func(cfg_func), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr),
		.cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(rdata), .mem_hit(ev[0]),
		.io_hit(ev[1]), .special_cycle(ev[2]), .master_req(ev[3]), .addr_parity_err(ev[4]),
		.data_parity_err(ev[5]), .master_owned_perr(ev[6]), .master_abort(ev[7]),
		.target_abort_rcv(ev[8]), .target_abort_sig(ev[9]), .mem_claim(mem_c), .io_claim(io_c),
		.master_grant_ok(mgo), .master_use_write_invalidate(mwi), .palette_snoop(snoop),
		.perr_assert(perr_a), .serr_assert(serr_a), .serr_driver_enable(system_error_enable));
	pci_agent_model agent (.op(op), .fn_sel(fs), .ev(ev));
	always #20 clock = ~clock;
	task complete_run;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// request spans one rising edge, read data is taken while it stands,
	// then an idle cycle so back-to-back calls never reassign in one step
	task acc(input logic w, input logic f, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		{cfg_sel, cfg_write, cfg_read, cfg_func} = {1'h1, w, !w, f};
		{cfg_addr, cfg_byte_en, cfg_wdata} = {a, be, d};
		@(negedge clock);
		q = rdata;
		{cfg_sel, cfg_write, cfg_read} = 3'h0;
		@(negedge clock);
	endtask : acc
	task rd(input logic f);
		acc(1'h0, f, 8'h04, 4'hf, 32'h0);
	endtask : rd
	task pulse(input logic [3:0] o, input logic [1:0] s);
		{op, fs} = {o, s};
		@(negedge clock);
		ep = {serr_a, perr_a};
		op = 4'hf;
		@(negedge clock);
	endtask : pulse
	task t_reset;
		rd(1'h0); chk(q, 32'h0210_0000);
		rd(1'h1); chk(q, 32'h0210_0000);
		acc(1'h0, 1'h0, 8'h08, 4'hf, 32'h0); chk(q, 32'h0);
		chk({29'h0, snoop, system_error_enable}, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task t_cmd;
		acc(1'h1, 1'h0, 8'h04, 4'h3, 32'hffff_ffff);
		rd(1'h0); chk(q, 32'h0210_0167);
		rd(1'h1); chk(q, 32'h0210_0000);
		chk({29'h0, snoop, system_error_enable}, 32'h3);
		$display("test command done");
	endtask : t_cmd
	task t_gate;
		for (int k = 0; k < 4; k++) begin
			{op, fs} = {k[3:0], 2'h3};
			#1 chk({26'h0, mem_c, io_c, mgo}, {26'h0, gexp[k]});
			@(negedge clock);
		end
		{op, fs} = {4'ha, 2'h3};
		#1 chk({26'h0, mem_c, io_c, mgo}, 32'h0);
		@(negedge clock);
		op = 4'hf;
		@(negedge clock);
		$display("test gating done");
	endtask : t_gate
	task t_err;
		pulse(4'h4, 2'h2); chk({30'h0, ep}, 32'h2);
		pulse(4'h5, 2'h1); chk({30'h0, ep}, 32'h1);
		pulse(4'h7, 2'h1);
		rd(1'h1); chk(q & MSK, 32'h8210_0000);
		rd(1'h0); chk(q & MSK, 32'ha210_0167);
		acc(1'h1, 1'h0, 8'h04, 4'h8, 32'h2000_0000);
		rd(1'h0); chk(q & MSK, 32'h8210_0167);
		acc(1'h1, 1'h0, 8'h04, 4'hc, 32'h0);
		rd(1'h0); chk(q & MSK, 32'h8210_0167);
		$display("test status done");
	endtask : t_err
	task t_off;
		acc(1'h1, 1'h0, 8'h04, 4'h3, 32'h0);
		acc(1'h1, 1'h1, 8'h04, 4'h1, 32'h0000_ffff);
		rd(1'h1); chk(q & 32'hffff, 32'h0067);
		chk({31'h0, system_error_enable}, 32'h0);
		pulse(4'h4, 2'h3); chk({31'h0, ep[1]}, 32'h0);
		pulse(4'h5, 2'h1); chk({31'h0, ep[0]}, 32'h1);
		$display("test enables done");
	endtask : t_off
	initial begin
		{clock, resetn, cfg_sel, cfg_func, cfg_write, cfg_read} = 6'h0;
		{cfg_addr, cfg_byte_en, cfg_wdata, op, fs} = {8'h0, 4'h0, 32'h0, 4'hf, 2'h0};
		repeat (16) @(negedge clock);
		resetn = 1'h1;
		repeat (3) @(negedge clock);
		t_reset;
		t_cmd;
		t_gate;
		t_err;
		t_off;
		complete_run;
	end
	initial begin
		#100000;
		n_fail++;
		complete_run;
	end
endmodule : tb_top
bind pci_config_command_status cfg_checker chk_i (.*);

// >>> src/cfg_cmd_defines.svh
`ifndef CFG_CMD_DEFINES_SVH
`define CFG_CMD_DEFINES_SVH

// configuration dword holding command (low half) and status (high half)
`define CMD_STATUS_DWORD_OFFSET 8'h04
`define STATUS_OFFSET 8'h06

// command register fields
`define CMD_IO_SPACE_BIT 0
`define CMD_MEM_SPACE_BIT 1
`define CMD_BUS_MASTER_BIT 2
`define CMD_PALETTE_SNOOP_BIT 5
`define CMD_PARITY_RESP_BIT 6
`define CMD_SYS_ERR_BIT 8
`define CMD_WRITABLE_MASK 16'h0167
`define CMD_RESET 16'h0000

// status register fields
`define STAT_TARGET_ABORT_SIG_BIT 11
`define STAT_TARGET_ABORT_RCV_BIT 12
`define STAT_MASTER_ABORT_BIT 13
`define STAT_SYS_ERR_SIG_BIT 14
`define STAT_PARITY_DET_BIT 15
`define STAT_DATA_PARITY_BIT 8
`define STAT_CLEARABLE_MASK 16'hf900
`define STAT_FIXED_BITS 16'h0210
`define STAT_RESET 16'h0210

`endif

// >>> src/cfg_cmd_pkg.sv
package cfg_cmd_pkg;
	// per-function error events, one bit each, aligned to status layout
	typedef struct packed {
		logic parity_detected;
		logic sys_err_signalled;
		logic master_abort_received;
		logic target_abort_received;
		logic target_abort_signalled;
		logic data_parity_master;
	} func_events_t;

	typedef struct packed {
		logic [15:0] cmd_q;
		logic [15:0] stat_q;
	} func_state_t;
endpackage : cfg_cmd_pkg

// >>> src/func_cfg_if.sv
`timescale 1ns/1ns
// link between the bank top and one function's register slice
interface func_cfg_if;
	logic wr_cmd;
	logic wr_stat;
	// whole dword lanes; a slice takes lanes 1:0 for command and 3:2 for status
	logic [3:0] byte_en;
	logic [31:0] wdata;
	cfg_cmd_pkg::func_events_t events;
	logic [15:0] cmd;
	logic [15:0] stat;

	modport bank (output wr_cmd, output wr_stat, output byte_en, output wdata,
		output events, input cmd, input stat);
	modport func (input wr_cmd, input wr_stat, input byte_en, input wdata,
		input events, output cmd, output stat);
endinterface : func_cfg_if

// >>> src/func_cmd_status.sv
`timescale 1ns/1ns
`include "cfg_cmd_defines.svh"

// one function's command and status pair
module func_cmd_status (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// bank side
	func_cfg_if.func port
);
	cfg_cmd_pkg::func_state_t s_q, s_d;
	logic [15:0] cmd_mask;
	logic [15:0] stat_mask;
	logic [15:0] set_bits;

	always_comb begin
		s_d = s_q;
		cmd_mask = {{8{port.byte_en[1]}}, {8{port.byte_en[0]}}};
		stat_mask = {{8{port.byte_en[3]}}, {8{port.byte_en[2]}}};
		set_bits = 16'h0000;
		set_bits[`STAT_PARITY_DET_BIT] = port.events.parity_detected;
		set_bits[`STAT_SYS_ERR_SIG_BIT] = port.events.sys_err_signalled;
		set_bits[`STAT_MASTER_ABORT_BIT] = port.events.master_abort_received;
		set_bits[`STAT_TARGET_ABORT_RCV_BIT] = port.events.target_abort_received;
		set_bits[`STAT_TARGET_ABORT_SIG_BIT] = port.events.target_abort_signalled;
		set_bits[`STAT_DATA_PARITY_BIT] = port.events.data_parity_master;
		if (port.wr_cmd) begin
			// only the documented read/write bits ever hold a one
			s_d.cmd_q = (s_q.cmd_q & ~(cmd_mask & `CMD_WRITABLE_MASK))
				| (port.wdata[15:0] & cmd_mask & `CMD_WRITABLE_MASK);
		end
		// write-one clears; a same-cycle event wins over the clear
		if (port.wr_stat) begin
			s_d.stat_q = s_q.stat_q & ~(port.wdata[31:16] & stat_mask & `STAT_CLEARABLE_MASK);
		end
		s_d.stat_q = ((s_d.stat_q | set_bits) & `STAT_CLEARABLE_MASK)
			| `STAT_FIXED_BITS;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{cmd_q: `CMD_RESET, stat_q: `STAT_RESET};
		end else begin
			s_q <= s_d;
		end
	end

	assign port.cmd = s_q.cmd_q;
	assign port.stat = s_q.stat_q;
endmodule : func_cmd_status

// >>> src/pci_config_command_status.sv
`timescale 1ns/1ns
`include "cfg_cmd_defines.svh"

// What this block does
// - separate command register per function
// - error enables ORed across both functions
// - command bits 15..10 read zero
// - fast back-to-back enable reads zero
// - bit 8 enables system-error driver, reset 0
// - address parity on serr needs bits 8,6
// - bit 6 gates parity error reporting
// - stepping bit hardwired zero
// - palette snoop bit read/write, reset 0
// - write-invalidate hardwired zero, plain writes
// - special cycle bit zero, never respond
// - bus master bit gates bus requests
// - memory space bit gates memory claims
// - io space bit gates io claims
// - status write-one clears, reads harmless
// - status at 06h resets 0210h
// - bit 15 set on any parity error
// - bit 13 set on master abort
// - devsel timing bits read 01b
// - capability list bit reads one
module pci_config_command_status (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// configuration access, dword at offset 04h
	input wire logic cfg_sel,
	input wire logic cfg_func,
	input wire logic cfg_write,
	input wire logic cfg_read,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_byte_en,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	// bus-side requests per function, from pci core logic
	input wire logic [1:0] mem_hit,
	input wire logic [1:0] io_hit,
	input wire logic [1:0] special_cycle,
	input wire logic [1:0] master_req,
	input wire logic [1:0] addr_parity_err,
	input wire logic [1:0] data_parity_err,
	input wire logic [1:0] master_owned_perr,
	input wire logic [1:0] master_abort,
	input wire logic [1:0] target_abort_rcv,
	input wire logic [1:0] target_abort_sig,
	// gated decisions
	output logic [1:0] mem_claim,
	output logic [1:0] io_claim,
	output logic [1:0] master_grant_ok,
	output logic master_use_write_invalidate,
	output logic [1:0] palette_snoop,
	output logic perr_assert,
	output logic serr_assert,
	output logic serr_driver_enable
);
	// registered outputs and read data share one state word
	typedef struct packed {
		logic [31:0] rdata_q;
		logic serr_q;
		logic perr_q;
	} top_state_t;

	// reset release
	logic [1:0] rst_sync_q;
	logic rst_n;
	top_state_t s_q;
	top_state_t s_d;

	// decoded configuration access
	logic dword_hit;
	logic cfg_wr_hit;
	logic cfg_rd_hit;
	logic cmd_lanes;
	logic stat_lanes;

	// per-function register views and read images
	logic [15:0] cmd_f0;
	logic [15:0] cmd_f1;
	logic [15:0] stat_f0;
	logic [15:0] stat_f1;
	logic [15:0] cmd_img_f0;
	logic [15:0] cmd_img_f1;
	logic [15:0] stat_img_f0;
	logic [15:0] stat_img_f1;
	logic [31:0] read_word;

	// per-function enables taken from the command registers
	logic [1:0] sys_err_en;
	logic [1:0] par_resp_en;
	logic [1:0] mem_en;
	logic [1:0] io_en;
	logic [1:0] master_en;
	logic [1:0] snoop_en;

	// combined enables and error decisions
	logic any_system_error_enable;
	logic any_par_en;
	logic any_addr_perr;
	logic any_data_perr;
	logic serr_event;
	logic perr_event;
	logic [1:0] parity_seen;
	logic [1:0] sys_err_seen;
	logic [1:0] master_perr_seen;

	func_cfg_if f0 ();
	func_cfg_if f1 ();

	// slices leave reset on a clock edge, never part way through a cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	func_cmd_status u_func0 (
		.clock(clock),
		.rst_n(rst_n),
		.port(f0.func)
	);
	func_cmd_status u_func1 (
		.clock(clock),
		.rst_n(rst_n),
		.port(f1.func)
	);

	// only the dword at 04h decodes; other offsets read zero and drop writes
	assign dword_hit = cfg_sel && (cfg_addr[7:2] == 6'(`CMD_STATUS_DWORD_OFFSET >> 2));
	assign cfg_wr_hit = dword_hit && cfg_write;
	assign cfg_rd_hit = dword_hit && cfg_read;
	// command in lanes 1:0, status in lanes 3:2
	assign cmd_lanes = |cfg_byte_en[1:0];
	assign stat_lanes = |cfg_byte_en[3:2];

	// write strobes, one function at a time
	assign f0.wr_cmd = cfg_wr_hit && !cfg_func && cmd_lanes;
	assign f1.wr_cmd = cfg_wr_hit && cfg_func && cmd_lanes;
	assign f0.wr_stat = cfg_wr_hit && !cfg_func && stat_lanes;
	assign f1.wr_stat = cfg_wr_hit && cfg_func && stat_lanes;

	// both slices see the whole dword, so one write may touch both halves
	assign f0.byte_en = cfg_byte_en;
	assign f1.byte_en = cfg_byte_en;
	assign f0.wdata = cfg_wdata;
	assign f1.wdata = cfg_wdata;

	// register views
	assign cmd_f0 = f0.cmd;
	assign cmd_f1 = f1.cmd;
	assign stat_f0 = f0.stat;
	assign stat_f1 = f1.stat;

	// enable bits, one copy per function
	assign sys_err_en[0] = cmd_f0[`CMD_SYS_ERR_BIT];
	assign sys_err_en[1] = cmd_f1[`CMD_SYS_ERR_BIT];
	assign par_resp_en[0] = cmd_f0[`CMD_PARITY_RESP_BIT];
	assign par_resp_en[1] = cmd_f1[`CMD_PARITY_RESP_BIT];
	assign mem_en[0] = cmd_f0[`CMD_MEM_SPACE_BIT];
	assign mem_en[1] = cmd_f1[`CMD_MEM_SPACE_BIT];
	assign io_en[0] = cmd_f0[`CMD_IO_SPACE_BIT];
	assign io_en[1] = cmd_f1[`CMD_IO_SPACE_BIT];
	assign master_en[0] = cmd_f0[`CMD_BUS_MASTER_BIT];
	assign master_en[1] = cmd_f1[`CMD_BUS_MASTER_BIT];
	assign snoop_en[0] = cmd_f0[`CMD_PALETTE_SNOOP_BIT];
	assign snoop_en[1] = cmd_f1[`CMD_PALETTE_SNOOP_BIT];

	assign any_system_error_enable = |sys_err_en;
	assign any_par_en = |par_resp_en;
	assign any_addr_perr = |addr_parity_err;
	assign any_data_perr = |data_parity_err;
	// address parity goes out on serr only with both enables set
	assign serr_event = any_system_error_enable && any_par_en && any_addr_perr;
	assign perr_event = any_par_en && any_data_perr;

	// read images rebuilt field by field, so fixed bits never hang on storage
	assign cmd_img_f0 = {
		6'h00,
		1'b0,
		sys_err_en[0],
		1'b0,
		par_resp_en[0],
		snoop_en[0],
		1'b0,
		1'b0,
		master_en[0],
		mem_en[0],
		io_en[0]
	};
	assign cmd_img_f1 = {
		6'h00,
		1'b0,
		sys_err_en[1],
		1'b0,
		par_resp_en[1],
		snoop_en[1],
		1'b0,
		1'b0,
		master_en[1],
		mem_en[1],
		io_en[1]
	};
	assign stat_img_f0 = {
		stat_f0[15:11],
		2'b01,
		stat_f0[8],
		1'b0,
		1'b0,
		1'b0,
		1'b1,
		4'h0
	};
	assign stat_img_f1 = {
		stat_f1[15:11],
		2'b01,
		stat_f1[8],
		1'b0,
		1'b0,
		1'b0,
		1'b1,
		4'h0
	};

	// a read only copies the flags, it never clears them
	always_comb begin
		if (cfg_func) begin
			read_word = {stat_img_f1, cmd_img_f1};
		end else begin
			read_word = {stat_img_f0, cmd_img_f0};
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.serr_q = serr_event;
		s_d.perr_q = perr_event;
		s_d.rdata_q = 32'h00000000;
		if (cfg_rd_hit) begin
			s_d.rdata_q = read_word;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{rdata_q: 32'h00000000, serr_q: 1'b0, perr_q: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// registered outputs
	assign cfg_rdata = s_q.rdata_q;
	assign perr_assert = s_q.perr_q;
	assign serr_assert = s_q.serr_q;
	// either function may turn on the shared driver
	assign serr_driver_enable = any_system_error_enable;
	// mastering only ever issues plain memory writes
	assign master_use_write_invalidate = 1'b0;

	// bus-side gating; special cycles are never claimed
	always_comb begin
		mem_claim[0] = mem_hit[0] && mem_en[0];
		mem_claim[1] = mem_hit[1] && mem_en[1];
		io_claim[0] = io_hit[0] && io_en[0] && !special_cycle[0];
		io_claim[1] = io_hit[1] && io_en[1] && !special_cycle[1];
		master_grant_ok[0] = master_req[0] && master_en[0];
		master_grant_ok[1] = master_req[1] && master_en[1];
		palette_snoop[0] = snoop_en[0];
		palette_snoop[1] = snoop_en[1];
	end

	// per-function events; parity detection ignores the enables
	assign parity_seen = addr_parity_err | data_parity_err;
	assign sys_err_seen = {2{serr_event}} & addr_parity_err;
	assign master_perr_seen = master_owned_perr & par_resp_en;

	always_comb begin
		f0.events.parity_detected = parity_seen[0];
		f0.events.sys_err_signalled = sys_err_seen[0];
		f0.events.master_abort_received = master_abort[0];
		f0.events.target_abort_received = target_abort_rcv[0];
		f0.events.target_abort_signalled = target_abort_sig[0];
		f0.events.data_parity_master = master_perr_seen[0];
	end

	always_comb begin
		f1.events.parity_detected = parity_seen[1];
		f1.events.sys_err_signalled = sys_err_seen[1];
		f1.events.master_abort_received = master_abort[1];
		f1.events.target_abort_received = target_abort_rcv[1];
		f1.events.target_abort_signalled = target_abort_sig[1];
		f1.events.data_parity_master = master_perr_seen[1];
	end
endmodule : pci_config_command_status
